// *** hw/fcmd_regs.svh ***
// fcmd_regs.svh: offsets, command codes, status bit positions and timing counts
// assumes: included by bare name from the controller files
`ifndef FCMD_REGS_SVH
`define FCMD_REGS_SVH

// ****************************************
// controller register offsets (word index)
// ****************************************
`define FCMD_REG_CTRL      4'h0
`define FCMD_REG_ADDR      4'h1
`define FCMD_REG_WDATA     4'h2
`define FCMD_REG_STAT      4'h3
`define FCMD_REG_RDATA     4'h4

// ****************************************
// control register fields
// ****************************************
`define FCMD_CTRL_OP_LSB   0
`define FCMD_CTRL_OP_W     4
`define FCMD_CTRL_RST_BIT  4

// ****************************************
// device command codes
// ****************************************
`define FCMD_CODE_READ_ARRAY   8'hff
`define FCMD_CODE_PROGRAM      8'h40
`define FCMD_CODE_PROGRAM_ALT  8'h10
`define FCMD_CODE_ERASE_SETUP  8'h20
`define FCMD_CODE_CONFIRM      8'hd0
`define FCMD_CODE_SUSPEND      8'hb0
`define FCMD_CODE_READ_STATUS  8'h70
`define FCMD_CODE_CLEAR_STATUS 8'h50
`define FCMD_CODE_READ_ID      8'h90

// ****************************************
// device status bit positions and reset value
// ****************************************
`define FCMD_SR_BLOCK_LOCK_ERR 1
`define FCMD_SR_PROG_SUSP      2
`define FCMD_SR_PROG_VOLT_ERR  3
`define FCMD_SR_PROG_ERR       4
`define FCMD_SR_ERASE_ERR      5
`define FCMD_SR_ERASE_SUSP     6
`define FCMD_SR_READY          7
`define FCMD_SR_RESET_VAL      8'h80

// ****************************************
// bus timing, ns and derived 10 ns cycles
// ****************************************
`define FCMD_CLK_NS        10
`define FCMD_PULSE_NS      60
`define FCMD_PULSE_CYC     ((`FCMD_PULSE_NS + `FCMD_CLK_NS - 1) / `FCMD_CLK_NS)
`define FCMD_RST_NS        150
`define FCMD_RST_CYC       ((`FCMD_RST_NS + `FCMD_CLK_NS - 1) / `FCMD_CLK_NS)

`endif

// *** hw/fcmd_pkg.sv ***
// fcmd_pkg: types of the flash command controller
// assumes: nothing; used by package::name only
package fcmd_pkg;
	// host operations ordered through the control register
	typedef enum logic [3:0] {
		FCMD_OP_NONE,
		FCMD_OP_READ_ARRAY,
		FCMD_OP_READ_STATUS,
		FCMD_OP_READ_ID,
		FCMD_OP_CLEAR_STATUS,
		FCMD_OP_PROGRAM,
		FCMD_OP_ERASE,
		FCMD_OP_SUSPEND,
		FCMD_OP_RESUME,
		FCMD_OP_READ,
		FCMD_OP_BAD_ERASE
	} fcmd_op_e;

	// mode the device is believed to be in
	typedef enum logic [1:0] {
		FCMD_MODE_ARRAY,
		FCMD_MODE_STATUS,
		FCMD_MODE_ID
	} fcmd_mode_e;
endpackage

// *** hw/fcmd_sync.sv ***
// fcmd_sync: two-flop synchroniser for one pin level
// assumes: input from outside the clk domain
`timescale 1ns/1ps
module fcmd_sync (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	// ****************************************
	// synchroniser chain
	// ****************************************
	// reset to zero; the first flop feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // fcmd_sync

// *** hw/fcmd_cycle.sv ***
// fcmd_cycle: one timed write or read bus cycle on the flash pins
// assumes: started by a one-cycle pulse while idle; data input already synchronised
`timescale 1ns/1ps
`include "fcmd_regs.svh"
module fcmd_cycle #(
	parameter int PULSE_CYC = `FCMD_PULSE_CYC
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] dq_sync,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             cs_n,
	output logic             oe_n,
	output logic             we_n,
	output logic             dq_oe,
	output logic [15:0]      dq_out
);
	typedef enum logic [1:0] {CYC_IDLE, CYC_STROBE, CYC_RECOVER} fcmd_cyc_e;

	fcmd_cyc_e   st_r, st_nxt;
	logic [7:0]  cnt_r, cnt_nxt;
	logic        wr_r, wr_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic [15:0] wd_r, wd_nxt;
	logic        done_r, done_nxt;

	// ****************************************
	// cycle sequencing
	// ****************************************
	// strobe held a whole pulse; data sampled at the end, before strobes rise
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		wr_nxt   = wr_r;
		rd_nxt   = rd_r;
		wd_nxt   = wd_r;
		done_nxt = 1'b0;
		unique case (st_r)
			CYC_IDLE: begin
				if (start) begin
					st_nxt  = CYC_STROBE;
					cnt_nxt = 8'(PULSE_CYC + 2);
					wr_nxt  = is_write;
					wd_nxt  = wdata;
				end
			end
			CYC_STROBE: begin
				if (cnt_r == 8'h00) begin
					st_nxt  = CYC_RECOVER;
					cnt_nxt = 8'(PULSE_CYC);
					rd_nxt  = dq_sync; // extra two cycles cover the synchroniser
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			CYC_RECOVER: begin
				if (cnt_r == 8'h00) begin
					st_nxt   = CYC_IDLE;
					done_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
		endcase
	end

	// registers only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r   <= CYC_IDLE;
			cnt_r  <= 8'h00;
			wr_r   <= 1'b0;
			rd_r   <= 16'h0000;
			wd_r   <= 16'h0000;
			done_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			wr_r   <= wr_nxt;
			rd_r   <= rd_nxt;
			wd_r   <= wd_nxt;
			done_r <= done_nxt;
		end
	end

	// pin drive: write latches on we_n rise with oe_n high; read keeps we_n high
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_n   <= 1'b1;
			oe_n   <= 1'b1;
			we_n   <= 1'b1;
			dq_oe  <= 1'b0;
			dq_out <= 16'h0000;
		end else begin
			cs_n   <= (st_nxt == CYC_IDLE);
			oe_n   <= !(st_nxt == CYC_STROBE && !wr_nxt);
			we_n   <= !(st_nxt == CYC_STROBE && wr_nxt);
			dq_oe  <= (st_nxt != CYC_IDLE) && wr_nxt;
			dq_out <= wd_nxt;
		end
	end

	assign busy  = (st_r != CYC_IDLE);
	assign done  = done_r;
	assign rdata = rd_r;
endmodule // fcmd_cycle

// *** hw/fcmd_ctrl.sv ***
// fcmd_ctrl: host-side controller that drives a parallel NOR flash command decoder
// assumes: flash pins on the outside, a plain register port toward software
`timescale 1ns/1ps
`include "fcmd_regs.svh"
module fcmd_ctrl #(
	parameter int ADDR_W    = 22,
	parameter int PULSE_CYC = `FCMD_PULSE_CYC,
	parameter int RST_CYC   = `FCMD_RST_CYC
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic                   flash_cs_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic                   flash_reset_powerdown_n,
	output logic [15:0]            flash_dq_out,
	output logic                   flash_dq_oe,
	input  wire logic [15:0]       flash_dq_in
);
	typedef enum logic [2:0] {
		ST_RESET, ST_IDLE, ST_CMD, ST_SECOND, ST_READ, ST_REFUSE
	} fcmd_st_e;

	// ****************************************
	// state
	// ****************************************
	fcmd_st_e               st_r, st_nxt;
	fcmd_pkg::fcmd_mode_e   mode_r, mode_nxt;
	fcmd_pkg::fcmd_op_e     op_r, op_nxt;
	logic [ADDR_W-1:0]      addr_r, addr_nxt;
	logic [15:0]            wdata_r, wdata_nxt;
	logic [15:0]            rdata_r, rdata_nxt;
	logic [7:0]             cnt_r, cnt_nxt;
	logic                   rst_pin_r, rst_pin_nxt;
	logic                   running_r, running_nxt;   // program or erase in flight
	logic                   suspended_r, suspended_nxt;
	logic                   refused_r, refused_nxt;   // sticky, cleared by a new order
	logic                   done_r, done_nxt;         // sticky, cleared by a new order
	logic [31:0]            rdout_r, rdout_nxt;
	logic                   cyc_start, cyc_write;
	logic [15:0]            cyc_wdata;
	logic                   cyc_busy, cyc_done;
	logic [15:0]            cyc_rdata;
	logic [15:0]            dq_sync;
	logic                   cyc_cs_n, cyc_oe_n, cyc_we_n, cyc_dq_oe;
	logic [15:0]            cyc_dq_out;

	// ****************************************
	// helpers
	// ****************************************
	// command code for an order; reserved codes are never produced
	function automatic logic [7:0] op_code(input fcmd_pkg::fcmd_op_e op);
		unique case (op)
			fcmd_pkg::FCMD_OP_READ_ARRAY:   op_code = `FCMD_CODE_READ_ARRAY;
			fcmd_pkg::FCMD_OP_READ_STATUS:  op_code = `FCMD_CODE_READ_STATUS;
			fcmd_pkg::FCMD_OP_READ_ID:      op_code = `FCMD_CODE_READ_ID;
			fcmd_pkg::FCMD_OP_CLEAR_STATUS: op_code = `FCMD_CODE_CLEAR_STATUS;
			fcmd_pkg::FCMD_OP_PROGRAM:      op_code = `FCMD_CODE_PROGRAM;
			fcmd_pkg::FCMD_OP_ERASE:        op_code = `FCMD_CODE_ERASE_SETUP;
			fcmd_pkg::FCMD_OP_BAD_ERASE:    op_code = `FCMD_CODE_ERASE_SETUP;
			fcmd_pkg::FCMD_OP_SUSPEND:      op_code = `FCMD_CODE_SUSPEND;
			fcmd_pkg::FCMD_OP_RESUME:       op_code = `FCMD_CODE_CONFIRM;
			default:                        op_code = `FCMD_CODE_READ_ARRAY;
		endcase
	endfunction

	// orders the device would ignore now are refused here instead
	function automatic logic op_allowed(input fcmd_pkg::fcmd_op_e op,
			input logic running, input logic suspended);
		if (op == fcmd_pkg::FCMD_OP_NONE || op > fcmd_pkg::FCMD_OP_BAD_ERASE)
			op_allowed = 1'b0;
		else if (running)
			op_allowed = (op == fcmd_pkg::FCMD_OP_READ_STATUS) ||
				(op == fcmd_pkg::FCMD_OP_SUSPEND) || (op == fcmd_pkg::FCMD_OP_READ);
		else if (suspended)
			op_allowed = (op != fcmd_pkg::FCMD_OP_PROGRAM) &&
				(op != fcmd_pkg::FCMD_OP_ERASE) && (op != fcmd_pkg::FCMD_OP_BAD_ERASE) &&
				(op != fcmd_pkg::FCMD_OP_SUSPEND) && (op != fcmd_pkg::FCMD_OP_CLEAR_STATUS);
		else
			op_allowed = (op != fcmd_pkg::FCMD_OP_SUSPEND) &&
				(op != fcmd_pkg::FCMD_OP_RESUME);
	endfunction

	// ****************************************
	// pin data synchroniser and bus cycle engine
	// ****************************************
	for (genvar i = 0; i < 16; i++) begin : g_sync
		fcmd_sync u_sync (
			.clk    (clk),
			.arst_n (arst_n),
			.d      (flash_dq_in[i]),
			.q      (dq_sync[i])
		);
	end

	fcmd_cycle #(.PULSE_CYC(PULSE_CYC)) u_cycle (
		.clk      (clk),
		.arst_n   (arst_n),
		.start    (cyc_start),
		.is_write (cyc_write),
		.wdata    (cyc_wdata),
		.dq_sync  (dq_sync),
		.busy     (cyc_busy),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.cs_n     (cyc_cs_n),
		.oe_n     (cyc_oe_n),
		.we_n     (cyc_we_n),
		.dq_oe    (cyc_dq_oe),
		.dq_out   (cyc_dq_out)
	);

	// ****************************************
	// order sequencing
	// ****************************************
	// one order at a time; software polls busy before the next
	always_comb begin
		st_nxt        = st_r;
		mode_nxt      = mode_r;
		op_nxt        = op_r;
		addr_nxt      = addr_r;
		wdata_nxt     = wdata_r;
		rdata_nxt     = rdata_r;
		cnt_nxt       = cnt_r;
		rst_pin_nxt   = rst_pin_r;
		running_nxt   = running_r;
		suspended_nxt = suspended_r;
		refused_nxt   = refused_r;
		done_nxt      = done_r;
		cyc_start     = 1'b0;
		cyc_write     = 1'b1;
		cyc_wdata     = {8'h00, op_code(op_r)};
		if (reg_wr && reg_addr == `FCMD_REG_ADDR)
			addr_nxt = reg_wdata[ADDR_W-1:0];
		if (reg_wr && reg_addr == `FCMD_REG_WDATA)
			wdata_nxt = reg_wdata[15:0];
		unique case (st_r)
			ST_RESET: begin
				if (cnt_r == 8'h00) begin
					rst_pin_nxt = 1'b1;
					st_nxt      = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			ST_IDLE: begin
				if (reg_wr && reg_addr == `FCMD_REG_CTRL) begin
					op_nxt      = fcmd_pkg::fcmd_op_e'(reg_wdata[`FCMD_CTRL_OP_W-1:0]);
					refused_nxt = 1'b0;
					done_nxt    = 1'b0;
					if (reg_wdata[`FCMD_CTRL_RST_BIT]) begin
						// power-down aborts anything in flight
						rst_pin_nxt   = 1'b0;
						cnt_nxt       = 8'(RST_CYC);
						st_nxt        = ST_RESET;
						mode_nxt      = fcmd_pkg::FCMD_MODE_ARRAY;
						running_nxt   = 1'b0;
						suspended_nxt = 1'b0;
					end else if (!op_allowed(op_nxt, running_r, suspended_r)) begin
						refused_nxt = 1'b1;
					end else if (op_nxt == fcmd_pkg::FCMD_OP_READ) begin
						// no read-array issued here; software orders it first
						st_nxt = ST_READ;
					end else begin
						st_nxt = ST_CMD;
					end
				end
			end
			ST_CMD: begin
				// first write: the command byte
				cyc_start = !cyc_busy && !cyc_done;
				if (cyc_done) begin
					unique case (op_r)
						fcmd_pkg::FCMD_OP_READ_ARRAY:  mode_nxt = fcmd_pkg::FCMD_MODE_ARRAY;
						fcmd_pkg::FCMD_OP_READ_ID:     mode_nxt = fcmd_pkg::FCMD_MODE_ID;
						fcmd_pkg::FCMD_OP_READ_STATUS: mode_nxt = fcmd_pkg::FCMD_MODE_STATUS;
						fcmd_pkg::FCMD_OP_SUSPEND:     mode_nxt = fcmd_pkg::FCMD_MODE_STATUS;
						fcmd_pkg::FCMD_OP_RESUME: begin
							mode_nxt      = fcmd_pkg::FCMD_MODE_STATUS;
							running_nxt   = 1'b1;
							suspended_nxt = 1'b0;
						end
						default: ;
					endcase
					if (op_r == fcmd_pkg::FCMD_OP_SUSPEND) begin
						running_nxt   = 1'b0;
						suspended_nxt = 1'b1;
					end
					if (op_r == fcmd_pkg::FCMD_OP_PROGRAM || op_r == fcmd_pkg::FCMD_OP_ERASE ||
							op_r == fcmd_pkg::FCMD_OP_BAD_ERASE)
						st_nxt = ST_SECOND;
					else begin
						st_nxt   = ST_IDLE;
						done_nxt = 1'b1;
					end
				end
			end
			ST_SECOND: begin
				// second write: data, erase confirm, or a deliberate non-confirm
				cyc_start = !cyc_busy && !cyc_done;
				if (op_r == fcmd_pkg::FCMD_OP_PROGRAM)
					cyc_wdata = wdata_r;
				else if (op_r == fcmd_pkg::FCMD_OP_ERASE)
					cyc_wdata = {8'h00, `FCMD_CODE_CONFIRM};
				else
					cyc_wdata = {8'h00, `FCMD_CODE_READ_STATUS};
				if (cyc_done) begin
					mode_nxt    = fcmd_pkg::FCMD_MODE_STATUS;
					running_nxt = (op_r != fcmd_pkg::FCMD_OP_BAD_ERASE);
					st_nxt      = ST_IDLE;
					done_nxt    = 1'b1;
				end
			end
			ST_READ: begin
				// address held from before the strobe to after it
				cyc_start = !cyc_busy && !cyc_done;
				cyc_write = 1'b0;
				if (cyc_done) begin
					rdata_nxt = cyc_rdata;
					if (mode_r == fcmd_pkg::FCMD_MODE_STATUS) begin
						// ready bit ends the running operation
						if (cyc_rdata[`FCMD_SR_READY] && running_r)
							running_nxt = 1'b0;
						rdata_nxt    = {8'h00, cyc_rdata[7:0]};
					end
					st_nxt   = ST_IDLE;
					done_nxt = 1'b1;
				end
			end
			ST_REFUSE: st_nxt = ST_IDLE;
		endcase
	end

	// ****************************************
	// register read port
	// ****************************************
	// read data valid only in the cycle after the strobe
	always_comb begin
		rdout_nxt = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`FCMD_REG_CTRL:  rdout_nxt = {28'h000_0000, op_r};
				`FCMD_REG_ADDR:  rdout_nxt = 32'(addr_r);
				`FCMD_REG_WDATA: rdout_nxt = {16'h0000, wdata_r};
				`FCMD_REG_STAT:  rdout_nxt = {24'h00_0000, suspended_r, running_r,
					mode_r, refused_r, done_r, !rst_pin_r, st_r != ST_IDLE};
				`FCMD_REG_RDATA: rdout_nxt = {16'h0000, rdata_r};
				default:         rdout_nxt = 32'h0000_0000;
			endcase
		end
	end

	// registers only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r        <= ST_RESET;
			mode_r      <= fcmd_pkg::FCMD_MODE_ARRAY;
			op_r        <= fcmd_pkg::FCMD_OP_NONE;
			addr_r      <= '0;
			wdata_r     <= 16'h0000;
			rdata_r     <= 16'h0000;
			cnt_r       <= 8'(RST_CYC);
			rst_pin_r   <= 1'b0;
			running_r   <= 1'b0;
			suspended_r <= 1'b0;
			refused_r   <= 1'b0;
			done_r      <= 1'b0;
			rdout_r     <= 32'h0000_0000;
		end else begin
			st_r        <= st_nxt;
			mode_r      <= mode_nxt;
			op_r        <= op_nxt;
			addr_r      <= addr_nxt;
			wdata_r     <= wdata_nxt;
			rdata_r     <= rdata_nxt;
			cnt_r       <= cnt_nxt;
			rst_pin_r   <= rst_pin_nxt;
			running_r   <= running_nxt;
			suspended_r <= suspended_nxt;
			refused_r   <= refused_nxt;
			done_r      <= done_nxt;
			rdout_r     <= rdout_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// pin strobes come from flops inside the cycle engine
	assign reg_rdata               = rdout_r;
	assign flash_addr              = addr_r;
	assign flash_reset_powerdown_n = rst_pin_r;
	assign flash_cs_n              = cyc_cs_n;
	assign flash_oe_n              = cyc_oe_n;
	assign flash_we_n              = cyc_we_n;
	assign flash_dq_oe             = cyc_dq_oe;
	assign flash_dq_out            = cyc_dq_out;
endmodule // fcmd_ctrl

// *** verif/fcmd_checker.sv ***
// fcmd_checker: concurrent checks on the controller's flash pins and register port
// assumes: bound into fcmd_ctrl, one clock domain, async active-low reset
`timescale 1ns/1ps
module fcmd_checker #(
	parameter int ADDR_W  = 22,
	parameter int RST_CYC = 15
) (
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic              flash_cs_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_we_n,
	input wire logic              flash_reset_powerdown_n,
	input wire logic              flash_dq_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// cycles the flash reset pin has been low, cleared while it is high
	int unsigned low_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			low_cnt <= 0;
		else if (flash_reset_powerdown_n)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end

	// strobe phases: four cycles are checked; a pulse lasts PULSE_CYC + 3 cycles, five at the small pulse setting
	sequence s_read_hold;
		(!flash_oe_n && !flash_cs_n && flash_we_n && flash_reset_powerdown_n)[*4];
	endsequence
	sequence s_write_hold;
		(!flash_we_n && !flash_cs_n && flash_oe_n && flash_dq_oe)[*4];
	endsequence

	a_read_levels: assert property ($fell(flash_oe_n) |-> s_read_hold)
		else $error("read strobe without the read pin levels");
	a_write_levels: assert property ($fell(flash_we_n) |-> s_write_hold)
		else $error("write strobe without select or driven data");
	a_addr_steady: assert property (!flash_oe_n && !$past(flash_oe_n)
		|-> $stable(flash_addr))
		else $error("address moved during a read");
	a_no_contention: assert property (flash_dq_oe |-> flash_oe_n)
		else $error("data driven while output enable is low");
	a_cs_covers_we: assert property ($rose(flash_we_n) |-> !flash_cs_n)
		else $error("write strobe did not end first");
	a_quiet_reset: assert property (!flash_reset_powerdown_n |-> flash_cs_n && flash_we_n)
		else $error("bus active while flash held in reset");
	a_wake_delay: assert property ($rose(flash_reset_powerdown_n) |-> low_cnt >= RST_CYC)
		else $error("flash reset pulse too short");
	a_rdata_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data outside its slot");
endmodule // fcmd_checker

bind fcmd_ctrl fcmd_checker #(
	.ADDR_W (ADDR_W),
	.RST_CYC(RST_CYC)
) chk_i (
	.clk                    (clk),
	.arst_n                 (arst_n),
	.reg_rd                 (reg_rd),
	.reg_rdata              (reg_rdata),
	.flash_addr             (flash_addr),
	.flash_cs_n             (flash_cs_n),
	.flash_oe_n             (flash_oe_n),
	.flash_we_n             (flash_we_n),
	.flash_reset_powerdown_n(flash_reset_powerdown_n),
	.flash_dq_oe            (flash_dq_oe)
);

// *** verif/fcmd_flash_model.sv ***
// fcmd_flash_model: behavioural flash command decoder with a timed sequencer
// assumes: pins straight from the controller, clk only paces the sequencer
`timescale 1ns/1ps
module fcmd_flash_model #(
	parameter int          BUSY   = 300,
	parameter logic [15:0] MFR_ID = 16'h0a0b, // arbitrary value
	parameter logic [15:0] DEV_ID = 16'h0c0d  // arbitrary value
) (
	input wire logic        clk,
	input wire logic [21:0] addr,
	input wire logic        cs_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic        rst_n,
	input wire logic [15:0] dq_in,
	output logic [15:0]     dq
);
	logic [15:0] mem [16];
	logic [15:0] val;
	logic [7:0]  st   = 8'h80;
	logic [1:0]  mode = 2'h0;
	logic [1:0]  arm  = 2'h0;
	logic        run  = 1'b0;
	logic        susp = 1'b0;
	logic        ers  = 1'b0;
	int          cnt  = 0;
	int          bad_cmds = 0;

	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 16'ha500 + 16'(i);
	end

	// reset pin low aborts everything and restarts in array mode
	always @(negedge rst_n) begin
		mode = 2'h0;
		arm = 2'h0;
		run = 1'b0;
		susp = 1'b0;
		st = 8'h80;
	end

	// sequencer: ready bit low until the count runs out; frozen while suspended
	always @(posedge clk) begin
		if (run && cnt > 0)
			cnt--;
		else if (run) begin
			run = 1'b0;
			st[7] = 1'b1;
		end
	end

	task automatic start(input logic e);
		run = 1'b1;
		st[7] = 1'b0;
		cnt = BUSY;
		ers = e;
		mode = 2'h1;
	endtask

	task automatic decode(input logic [15:0] d);
		if (arm == 2'h1) begin
			mem[addr[3:0]] = d;
			arm = 2'h0;
			start(1'b0);
		end else if (arm == 2'h2) begin
			arm = 2'h0;
			if (d[7:0] == 8'hd0) begin
				mem[addr[3:0]] = 16'hffff;
				start(1'b1);
			end else begin
				st[5:4] = 2'b11;
				mode = 2'h1;
			end
		end else if (run) begin
			if (d[7:0] == 8'h70)
				mode = 2'h1;
			else if (d[7:0] == 8'hb0) begin
				run = 1'b0;
				susp = 1'b1;
				st[7] = 1'b1;
				st[ers ? 6 : 2] = 1'b1;
			end
		end else case (d[7:0])
			8'hff: mode = 2'h0;
			8'h40, 8'h10: arm = 2'h1;
			8'h20: arm = 2'h2;
			8'h70: mode = 2'h1;
			8'h50: st = st & 8'hc5;
			8'h90: mode = 2'h2;
			8'hd0: if (susp) begin
				susp = 1'b0;
				st = st & 8'h3b;
				start(ers);
			end
			8'hb0: ;
			default: bad_cmds++;
		endcase
	endtask

	// command taken when the write strobe ends with the chip selected
	always @(posedge we_n) begin
		if (!cs_n && oe_n && rst_n)
			decode(dq_in);
	end

	always_comb begin
		case (mode)
			2'h1: val = {8'h00, st};
			2'h2: val = addr[0] ? DEV_ID : MFR_ID;
			default: val = mem[addr[3:0]];
		endcase
	end

	// undriven bus shows the inverse so a stale sample cannot pass
	assign dq = (!cs_n && !oe_n && we_n && rst_n) ? val : ~val;
endmodule // fcmd_flash_model

// *** verif/testbench.sv ***
// testbench: orders flash operations through the register port, checks results
// assumes: controller, flash model and bound checker compiled before it
`timescale 1ns/1ps
`include "fcmd_regs.svh"
module testbench;
	localparam int          BUSY = 300;
	localparam logic [15:0] MFR  = 16'h1a2b; // arbitrary value
	localparam logic [15:0] DEV  = 16'h3c4d; // arbitrary value
	logic        clk, arst_n, reg_wr, reg_rd;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, s;
	logic [21:0] flash_addr;
	logic        cs_n, oe_n, we_n, pd_n, dq_oe;
	logic [15:0] dq_out, m_dq;
	wire  [15:0] dq = dq_oe ? dq_out : m_dq;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;

	fcmd_ctrl #(.ADDR_W(22), .PULSE_CYC(2), .RST_CYC(2)) uut (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
		.flash_cs_n(cs_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_reset_powerdown_n(pd_n), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq)
	);
	fcmd_flash_model #(.BUSY(BUSY), .MFR_ID(MFR), .DEV_ID(DEV)) m (
		.clk(clk), .addr(flash_addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.rst_n(pd_n), .dq_in(dq), .dq(m_dq)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard: the whole sequence needs under two thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// poll busy; the last status word stays in s
	task automatic wait_idle();
		for (int i = 0; i < 200; i++) begin
			rd(`FCMD_REG_STAT, s);
			if (s[0] === 1'b0)
				break;
		end
		// poll limit spent counts as a mismatch
		if (s[0] !== 1'b0)
			failures++;
	endtask

	task automatic op(input logic [31:0] code);
		wr(`FCMD_REG_CTRL, code);
		wait_idle();
	endtask

	// one flash read at address a through the controller
	task automatic fread(input logic [21:0] a, input logic [15:0] exp);
		logic [31:0] v;
		wr(`FCMD_REG_ADDR, {10'h0, a});
		op(32'h9);
		rd(`FCMD_REG_RDATA, v);
		chk(32'(v[15:0]), 32'(exp));
	endtask

	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// main sequence: reset, modes, program with suspend, erase, errors
	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		wait_idle();
		fread(22'h3, 16'ha503);
		$display("reset test done");
		op(32'h2);
		chk(32'(s[5:2]), 32'h5);
		fread(22'h9, 16'h0080);
		op(32'h3);
		chk(32'(s[5:4]), 32'h2);
		fread(22'h0, MFR);
		fread(22'h1, DEV);
		op(32'h1);
		fread(22'h5, 16'ha505);
		$display("mode test done");
		wr(`FCMD_REG_ADDR, 32'h7);
		wr(`FCMD_REG_WDATA, 32'h1234);
		op(32'h5);
		chk(32'(s[6:4]), 32'h5);
		fread(22'h7, 16'h0000);
		op(32'h7);
		chk(32'(s[7:6]), 32'h2);
		fread(22'h7, 16'h0084);
		op(32'h8);
		fread(22'h7, 16'h0000);
		repeat (BUSY + 50) @(posedge clk);
		fread(22'h7, 16'h0080);
		op(32'h1);
		fread(22'h7, 16'h1234);
		$display("program test done");
		wr(`FCMD_REG_ADDR, 32'h2);
		op(32'h6);
		fread(22'h2, 16'h0000);
		op(32'h1);
		chk(32'(s[3]), 32'h1);
		repeat (BUSY + 50) @(posedge clk);
		fread(22'h2, 16'h0080);
		op(32'h1);
		fread(22'h2, 16'hffff);
		$display("erase test done");
		op(32'ha);
		fread(22'h2, 16'h00b0);
		op(32'h4);
		fread(22'h2, 16'h0080);
		op(32'h10);
		fread(22'h4, 16'ha504);
		rd(4'hf, s);
		chk(s, 32'h0);
		chk(32'(m.bad_cmds), 32'h0);
		$display("status test done");
		stop_test();
	end
endmodule // testbench
